// file: hdl/fps_host.sv
/*
  Host-side flash program/erase controller. Software loads address, data,
  command and divider into local registers and sets GO; the controller then
  walks the device through the check, select and three-step write sequence.
  Assumes a device register port answering reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module fps_host
  import fps_pkg::*;
#(
  parameter int OSC_HZ = 4_000_000
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  sw_addr_i,
  input  wire logic [15:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [15:0]      sw_rdata_o,
  output logic             dev_reg_wr_o,
  output logic             dev_reg_rd_o,
  output logic             dev_arr_wr_o,
  output logic [15:0]      dev_addr_o,
  output logic [15:0]      dev_wdata_o,
  input  wire logic [7:0]  dev_rdata_i
);
  typedef enum logic [15:0] {
    S_IDLE   = 16'h0001,
    S_DIV    = 16'h0002,
    S_BSEL   = 16'h0004,
    S_BREAD  = 16'h0008,
    S_CLEAR  = 16'h0010,
    S_SEL    = 16'h0020,
    S_SUPER  = 16'h0040,
    S_PAGE   = 16'h0080,
    S_EMPTY  = 16'h0100,
    S_WORD   = 16'h0200,
    S_SDATA  = 16'h0400,
    S_CMD    = 16'h0800,
    S_LAUNCH = 16'h1000,
    S_CHECK  = 16'h2000,
    S_WAIT   = 16'h4000,
    S_ABORT  = 16'h8000
  } fps_state_t;

  fps_bus_if bus();

  fps_state_t  state_q, state_d;
  logic [15:0] addr_q, data_q;
  logic [7:0]  cmd_q, div_q, page_q;
  logic [6:0]  ctrl_q;
  logic        busy_q, err_q, done_q, divset_q;
  logic        bank_q;
  logic [7:0]  devst_q;
  logic        div_ok;

  fps_div_calc #(.OSC_HZ(OSC_HZ)) u_div (
    .div_i (div_q),
    .ok_o  (div_ok)
  );

  fps_dev_port u_port (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .bus          (bus.drv),
    .dev_reg_wr_o (dev_reg_wr_o),
    .dev_reg_rd_o (dev_reg_rd_o),
    .dev_arr_wr_o (dev_arr_wr_o),
    .dev_addr_o   (dev_addr_o),
    .dev_wdata_o  (dev_wdata_o),
    .dev_rdata_i  (dev_rdata_i)
  );

  // software port decode
  wire wr_ctrl = sw_wr_i && (sw_addr_i == FPS_REG_CTRL);
  wire go      = wr_ctrl && sw_wdata_i[FPS_CTRL_GO] && !busy_q;
  wire idle_wr = sw_wr_i && !busy_q;
  wire cmd_ok  = (cmd_q == FPS_CMD_ERASE_VERIFY) || (cmd_q == FPS_CMD_WORD_PROGRAM)
              || (cmd_q == FPS_CMD_SECTOR_ERASE) || (cmd_q == FPS_CMD_MASS_ERASE);
  wire is_erase = (cmd_q == FPS_CMD_SECTOR_ERASE) || (cmd_q == FPS_CMD_MASS_ERASE);
  // sector erase address low bits do not matter; send them cleared
  wire [15:0] word_addr = (cmd_q == FPS_CMD_SECTOR_ERASE) ? {addr_q[15:9], 9'h000}
                                                          : {addr_q[15:1], 1'b0};
  wire [15:0] word_data = is_erase ? 16'h0000 : data_q;
  wire        st_err  = bus.rdata[FPS_ST_ACCESS_ERROR_FLAG] | bus.rdata[FPS_ST_PROTECTION_VIOLATION_FLAG];
  wire        st_emp  = bus.rdata[FPS_ST_BUF_EMPTY];
  wire        st_done = bus.rdata[FPS_ST_CMD_DONE];
  wire        want_page = ctrl_q[FPS_CTRL_PAGE] && (addr_q[15:14] == 2'b10);

  always_comb begin
    state_d   = state_q;
    bus.req   = 1'b0;
    bus.wr    = 1'b1;
    bus.word  = 1'b0;
    bus.addr  = 16'h0000;
    bus.wdata = 16'h0000;
    unique case (state_q)
      S_IDLE: begin
        // refuse to run with an illegal divider
        if (go && div_ok && cmd_ok) begin
          state_d = divset_q ? S_BSEL : S_DIV;
        end
      end
      S_DIV: begin
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_CLKDIV);
        bus.wdata = {8'h00, div_q};
        if (bus.done) state_d = S_BSEL;
      end
      S_BSEL: begin
        // visit each bank's status in turn
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_CONFIG);
        bus.wdata = {15'h0000, bank_q};
        if (bus.done) state_d = S_BREAD;
      end
      S_BREAD: begin
        bus.req  = 1'b1;
        bus.wr   = 1'b0;
        bus.addr = 16'(FPS_DEV_STATUS);
        if (bus.done) state_d = st_err ? S_CLEAR : (bank_q ? S_SEL : S_BSEL);
      end
      S_CLEAR: begin
        // a one clears the lock-out flags
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_STATUS);
        bus.wdata = {8'h00, FPS_ERR_CLEAR};
        if (bus.done) state_d = S_BREAD;
      end
      S_SEL: begin
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_CONFIG);
        bus.wdata = {15'h0000, ctrl_q[FPS_CTRL_BANK]};
        if (bus.done) state_d = S_SUPER;
      end
      S_SUPER: begin
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_CALIBRATION_CONFIG_REG);
        bus.wdata = {11'h000, ctrl_q[FPS_CTRL_SUPER], 4'h0};
        if (bus.done) state_d = want_page ? S_PAGE : S_EMPTY;
      end
      S_PAGE: begin
        // page select for the banked window
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_PAGE);
        bus.wdata = {8'h00, page_q};
        if (bus.done) state_d = S_EMPTY;
      end
      S_EMPTY: begin
        // wait for a free queue slot
        bus.req  = 1'b1;
        bus.wr   = 1'b0;
        bus.addr = 16'(FPS_DEV_STATUS);
        if (bus.done && st_emp) state_d = S_WORD;
      end
      S_WORD: begin
        // array word, or address register in super-user mode
        bus.req   = 1'b1;
        bus.word  = !ctrl_q[FPS_CTRL_SUPER];
        bus.addr  = ctrl_q[FPS_CTRL_SUPER] ? 16'(FPS_DEV_ADDR) : word_addr;
        bus.wdata = ctrl_q[FPS_CTRL_SUPER] ? word_addr : word_data;
        if (bus.done) state_d = ctrl_q[FPS_CTRL_SUPER] ? S_SDATA : S_CMD;
      end
      S_SDATA: begin
        // data register right after the address register
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_DATA);
        bus.wdata = word_data;
        if (bus.done) state_d = S_CMD;
      end
      S_CMD: begin
        // nothing else written between the three steps
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_CMD);
        bus.wdata = {8'h00, cmd_q};
        if (bus.done) state_d = ctrl_q[FPS_CTRL_ABORT] ? S_ABORT : S_LAUNCH;
      end
      S_LAUNCH: begin
        // one to the buffer-empty flag launches
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_STATUS);
        bus.wdata = {8'h00, FPS_LAUNCH};
        if (bus.done) state_d = S_CHECK;
      end
      S_CHECK: begin
        bus.req  = 1'b1;
        bus.wr   = 1'b0;
        bus.addr = 16'(FPS_DEV_STATUS);
        if (bus.done) state_d = st_err ? S_IDLE : (ctrl_q[FPS_CTRL_WAIT] ? S_WAIT : S_IDLE);
      end
      S_WAIT: begin
        // completion only once the queue has drained
        bus.req  = 1'b1;
        bus.wr   = 1'b0;
        bus.addr = 16'(FPS_DEV_STATUS);
        if (bus.done && (st_done || st_err)) state_d = S_IDLE;
      end
      S_ABORT: begin
        // zero to buffer-empty abandons the pending sequence
        bus.req   = 1'b1;
        bus.addr  = 16'(FPS_DEV_STATUS);
        bus.wdata = {8'h00, FPS_ABORT};
        if (bus.done) state_d = S_CHECK;
      end
      default: state_d = S_IDLE;
    endcase
  end

  wire leave   = (state_q != S_IDLE) && (state_d == S_IDLE);
  wire rd_done = bus.done && !bus.wr;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      busy_q  <= 1'b0;
      bank_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d != S_IDLE);
      if (state_q == S_BREAD && bus.done && !st_err) bank_q <= ~bank_q;
      else if (state_q == S_IDLE) bank_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divset_q <= 1'b0;
      err_q    <= 1'b0;
      done_q   <= 1'b0;
      devst_q  <= 8'h00;
    end else begin
      // mirror of the device's divider-loaded bit
      if (state_q == S_DIV && bus.done) divset_q <= 1'b1;
      if (rd_done) devst_q <= bus.rdata;
      if (go) done_q <= 1'b0;
      else if (leave) done_q <= 1'b1;
      // set wins over a software clear in the same cycle
      if ((state_q == S_CHECK || state_q == S_WAIT) && rd_done && st_err) err_q <= 1'b1;
      else if (go && !(div_ok && cmd_ok)) err_q <= 1'b1;
      else if (sw_wr_i && sw_addr_i == FPS_REG_STATUS && sw_wdata_i[FPS_STS_ERR]) err_q <= 1'b0;
    end
  end

  // parameters can only change while idle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      cmd_q  <= 8'h00;
      div_q  <= 8'h00;
      page_q <= 8'h00;
      ctrl_q <= 7'h00;
    end else if (idle_wr) begin
      if (sw_addr_i == FPS_REG_ADDR) addr_q <= sw_wdata_i;
      if (sw_addr_i == FPS_REG_DATA) data_q <= sw_wdata_i;
      if (sw_addr_i == FPS_REG_CMD)  cmd_q  <= sw_wdata_i[7:0];
      if (sw_addr_i == FPS_REG_DIV)  div_q  <= sw_wdata_i[7:0];
      if (sw_addr_i == FPS_REG_PAGE) page_q <= sw_wdata_i[7:0];
      if (wr_ctrl) ctrl_q <= {1'b0, sw_wdata_i[5:0] & 6'h3e};
    end
  end

  wire [15:0] status_w = {11'h000, done_q, !div_ok, divset_q, err_q, busy_q};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (sw_addr_i)
      FPS_REG_CTRL:   rd_mux = {9'h000, ctrl_q};
      FPS_REG_ADDR:   rd_mux = addr_q;
      FPS_REG_DATA:   rd_mux = data_q;
      FPS_REG_CMD:    rd_mux = {8'h00, cmd_q};
      FPS_REG_DIV:    rd_mux = {8'h00, div_q};
      FPS_REG_PAGE:   rd_mux = {8'h00, page_q};
      FPS_REG_STATUS: rd_mux = status_w;
      FPS_REG_DEVST:  rd_mux = {8'h00, devst_q};
      default:        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) sw_rdata_o <= 16'h0000;
    else if (sw_rd_i) sw_rdata_o <= rd_mux;
    else sw_rdata_o <= 16'h0000;
  end
endmodule

// file: inc/fps_pkg.sv
/*
  Package for the flash program/erase host controller: device register
  offsets, field positions, command codes, own register map, timing.
  Assumes a byte-wide device register bus and a 16-bit array write port.
*/
package fps_pkg;
  // device register byte offsets (within the flash register block)
  localparam logic [8:0] FPS_DEV_CLKDIV   = 9'h100;
  localparam logic [8:0] FPS_DEV_CONFIG   = 9'h103;
  localparam logic [8:0] FPS_DEV_STATUS   = 9'h105;
  localparam logic [8:0] FPS_DEV_CMD      = 9'h106;
  localparam logic [8:0] FPS_DEV_ADDR     = 9'h108;
  localparam logic [8:0] FPS_DEV_DATA     = 9'h10a;
  localparam logic [8:0] FPS_DEV_CALIBRATION_CONFIG_REG   = 9'h10c;
  localparam logic [8:0] FPS_DEV_PAGE     = 9'h030;

  // status bit positions
  localparam int FPS_ST_BUF_EMPTY = 7;
  localparam int FPS_ST_CMD_DONE  = 6;
  localparam int FPS_ST_PROTECTION_VIOLATION_FLAG     = 5;
  localparam int FPS_ST_ACCESS_ERROR_FLAG    = 4;
  localparam int FPS_ST_BLANK     = 2;
  // config / divider bit positions
  localparam int FPS_CFG_BANK     = 0;
  localparam int FPS_DIV_PRESCALE = 6;
  localparam int FPS_CAL_SUPER    = 4;

  localparam logic [7:0] FPS_CMD_ERASE_VERIFY = 8'h05;
  localparam logic [7:0] FPS_CMD_WORD_PROGRAM = 8'h20;
  localparam logic [7:0] FPS_CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] FPS_CMD_MASS_ERASE   = 8'h41;

  localparam logic [7:0] FPS_ERR_CLEAR = 8'h30;
  localparam logic [7:0] FPS_LAUNCH    = 8'h80;
  localparam logic [7:0] FPS_ABORT     = 8'h00;

  // own register map (word index on the software port)
  localparam logic [3:0] FPS_REG_CTRL   = 4'h0;
  localparam logic [3:0] FPS_REG_ADDR   = 4'h1;
  localparam logic [3:0] FPS_REG_DATA   = 4'h2;
  localparam logic [3:0] FPS_REG_CMD    = 4'h3;
  localparam logic [3:0] FPS_REG_DIV    = 4'h4;
  localparam logic [3:0] FPS_REG_PAGE   = 4'h5;
  localparam logic [3:0] FPS_REG_STATUS = 4'h6;
  localparam logic [3:0] FPS_REG_DEVST  = 4'h7;

  // control register fields
  localparam int FPS_CTRL_GO    = 0;
  localparam int FPS_CTRL_BANK  = 1;
  localparam int FPS_CTRL_SUPER = 2;
  localparam int FPS_CTRL_PAGE  = 3;
  localparam int FPS_CTRL_ABORT = 4;
  localparam int FPS_CTRL_WAIT  = 5;
  localparam int FPS_CTRL_DIV   = 6;

  // status register fields
  localparam int FPS_STS_BUSY   = 0;
  localparam int FPS_STS_ERR    = 1;
  localparam int FPS_STS_DIVOK  = 2;
  localparam int FPS_STS_BADDIV = 3;
  localparam int FPS_STS_DONE   = 4;

  // timing limits for the divider check
  localparam int FPS_CLK_HZ        = 20_000_000;
  localparam int FPS_TCLK_MIN_HZ   = 150_000;
  localparam int FPS_TCLK_MAX_HZ   = 200_000;
  localparam int FPS_BUS_MIN_HZ    = 1_000_000;
  localparam int FPS_SUM_MIN_NS    = 5_000;
  localparam int FPS_NUM_BANKS     = 2;
endpackage

// file: inc/fps_bus_if.sv
/*
  Interface carrying one device register access from the sequencer to the
  device port driver. Assumes single-clock use inside the controller.
*/
`timescale 1ns/1ps
interface fps_bus_if;
  logic        req;
  logic        wr;
  logic        word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [7:0]  rdata;

  modport seq (output req, output wr, output word, output addr, output wdata,
               input done, input rdata);
  modport drv (input req, input wr, input word, input addr, input wdata,
               output done, output rdata);
endinterface

// file: hdl/fps_dev_port.sv
/*
  Device port driver: turns one access request into a strobe on the device's
  register or array interface; a read completes once the device data is held.
  Assumes the device answers reads in the cycle after the strobe.
*/
`timescale 1ns/1ps
module fps_dev_port
  import fps_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  fps_bus_if.drv           bus,
  output logic             dev_reg_wr_o,
  output logic             dev_reg_rd_o,
  output logic             dev_arr_wr_o,
  output logic [15:0]      dev_addr_o,
  output logic [15:0]      dev_wdata_o,
  input  wire logic [7:0]  dev_rdata_i
);
  logic       busy_q;
  logic       rdw_q, rdv_q;
  logic [7:0] rdata_q;
  logic       start;

  assign start = bus.req & ~busy_q & ~rdw_q & ~rdv_q;
  // a read is done only when its data is held, never in the strobe cycle
  assign bus.done  = (busy_q & ~dev_reg_rd_o) | rdv_q;
  assign bus.rdata = rdata_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q       <= 1'b0;
      dev_reg_wr_o <= 1'b0;
      dev_reg_rd_o <= 1'b0;
      dev_arr_wr_o <= 1'b0;
      dev_addr_o   <= 16'h0000;
      dev_wdata_o  <= 16'h0000;
    end else begin
      busy_q       <= start;
      dev_reg_wr_o <= start & bus.wr & ~bus.word;
      dev_arr_wr_o <= start & bus.wr & bus.word;
      dev_reg_rd_o <= start & ~bus.wr;
      if (start) begin
        dev_addr_o  <= bus.addr;
        dev_wdata_o <= bus.wdata;
      end
    end
  end

  // device data stands in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdw_q   <= 1'b0;
      rdv_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      rdw_q <= dev_reg_rd_o;
      rdv_q <= rdw_q;
      if (rdw_q) rdata_q <= dev_rdata_i;
    end
  end
endmodule

// file: hdl/fps_div_calc.sv
/*
  Divider checker: judges whether a divider setting puts the timing clock
  inside its legal window for the given oscillator frequency.
  Assumes the oscillator frequency is a fixed parameter.
*/
`timescale 1ns/1ps
module fps_div_calc
  import fps_pkg::*;
#(
  parameter int OSC_HZ = 4_000_000
) (
  input  wire logic [7:0] div_i,
  output logic            ok_o
);
  if (OSC_HZ <= 0) begin : g_bad_osc
    $error("oscillator frequency must be positive");
  end

  logic [31:0] pre_hz;
  logic [31:0] tclk_hz;
  logic [31:0] tper_ns;
  logic [31:0] bper_ns;

  assign pre_hz  = div_i[FPS_DIV_PRESCALE] ? 32'(OSC_HZ / 8) : 32'(OSC_HZ);
  assign tclk_hz = pre_hz / (32'(div_i[5:0]) + 32'h1);
  assign tper_ns = (tclk_hz == 32'h0) ? 32'hffffffff : 32'(1_000_000_000) / tclk_hz;
  assign bper_ns = 32'(1_000_000_000 / FPS_CLK_HZ);

  // window on the timing clock and a floor on the summed periods
  assign ok_o = (tclk_hz >= 32'(FPS_TCLK_MIN_HZ)) && (tclk_hz <= 32'(FPS_TCLK_MAX_HZ))
             && ((tper_ns + bper_ns) >= 32'(FPS_SUM_MIN_NS))
             && (FPS_CLK_HZ >= FPS_BUS_MIN_HZ);
endmodule

// file: verification/fps_host_properties.sv
/* Checker of the flash host controller, watching its top-level ports only.
   Assumes one clock, async active-low reset, device reads answered next cycle. */
`timescale 1ns/1ps
module fps_host_properties
  import fps_pkg::*;
#(
  parameter int OSC_HZ = 4_000_000
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic        sw_wr_i,
  input wire logic        sw_rd_i,
  input wire logic [15:0] sw_rdata_o,
  input wire logic        dev_reg_wr_o,
  input wire logic        dev_reg_rd_o,
  input wire logic        dev_arr_wr_o,
  input wire logic [15:0] dev_addr_o,
  input wire logic [15:0] dev_wdata_o,
  input wire logic [7:0]  dev_rdata_i
);
  logic [8:0]  prev_q;
  logic [15:0] waddr_q, wdata_q;
  logic [7:0]  stat_q;
  logic        div_q, rdst_q;
  int          timing_clock;
  wire  [8:0]  ra  = dev_addr_o[8:0];
  wire         rw  = dev_reg_wr_o;
  wire         stb = dev_reg_wr_o | dev_reg_rd_o | dev_arr_wr_o;
  // timing clock that the divider byte on the bus would give
  assign timing_clock = OSC_HZ / ((dev_wdata_o[FPS_DIV_PRESCALE] ? 8 : 1) *
                          (int'(dev_wdata_o[5:0]) + 1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {prev_q, waddr_q, wdata_q, stat_q, div_q, rdst_q} <= '0;
    end else begin
      rdst_q <= dev_reg_rd_o && ra == FPS_DEV_STATUS;
      div_q  <= div_q | (rw && ra == FPS_DEV_CLKDIV);
      if (rdst_q) stat_q <= dev_rdata_i;
      // 1ff marks an array word write; no register sits there
      if (dev_arr_wr_o) prev_q <= 9'h1ff;
      else if (rw) prev_q <= ra;
      if (dev_arr_wr_o) begin
        waddr_q <= dev_addr_o;
        wdata_q <= dev_wdata_o;
      end
      if (rw && ra == FPS_DEV_ADDR) waddr_q <= dev_wdata_o;
      if (rw && ra == FPS_DEV_DATA) wdata_q <= dev_wdata_o;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_rdata_quiet: assert property (!$past(sw_rd_i) |-> sw_rdata_o == 16'h0000)
    else $error("stray read data");
  a_strobe_gap: assert property (stb |=> !stb)
    else $error("strobes back to back");
  a_word_ready: assert property ((dev_arr_wr_o || (rw && ra == FPS_DEV_ADDR)) |->
    stat_q[FPS_ST_BUF_EMPTY] && stat_q[5:4] == 2'b00)
    else $error("word without empty buffer");
  a_div_first: assert property (dev_arr_wr_o |-> div_q && !dev_addr_o[0])
    else $error("early or odd word write");
  a_after_word: assert property (rw && prev_q == 9'h1ff |-> ra == FPS_DEV_CMD)
    else $error("write after word");
  a_launch_next: assert property (rw && prev_q == FPS_DEV_CMD |->
    ra == FPS_DEV_STATUS && dev_wdata_o[7:0] == FPS_LAUNCH)
    else $error("no launch after command");
  a_super_pair: assert property (rw && prev_q == FPS_DEV_ADDR |-> ra == FPS_DEV_DATA)
    else $error("address without data");
  a_sector_zero: assert property (rw && ra == FPS_DEV_CMD &&
    dev_wdata_o[7:0] == FPS_CMD_SECTOR_ERASE |-> waddr_q[8:0] == 9'h000 && wdata_q == 16'h0000)
    else $error("sector erase not cleared");
  a_div_window: assert property (rw && ra == FPS_DEV_CLKDIV |->
    timing_clock >= FPS_TCLK_MIN_HZ && timing_clock <= FPS_TCLK_MAX_HZ)
    else $error("divider out of window");
  a_err_clear: assert property (rw && ra == FPS_DEV_STATUS && !dev_wdata_o[7] |->
    dev_wdata_o[7:0] == FPS_ERR_CLEAR)
    else $error("bad status write");

  c_launch: cover property (rw && ra == FPS_DEV_STATUS && dev_wdata_o[7:0] == FPS_LAUNCH);
  c_super: cover property (rw && prev_q == FPS_DEV_ADDR);
  c_clear: cover property (rw && ra == FPS_DEV_STATUS && dev_wdata_o[7:0] == FPS_ERR_CLEAR);
endmodule

// file: verification/fps_dev_model.sv
/* Behavioural flash device behind the controller's register and array port.
   Assumes one-cycle strobes; reads answer in the next cycle. */
`timescale 1ns/1ps
module fps_dev_model
  import fps_pkg::*;
#(
  parameter int RUN_CYC = 100
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        arr_wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        err_set_i,
  output logic [7:0]       rdata_o
);
  logic [7:0]  div_q, cmd_q, rd_d;
  logic [15:0] arr_addr_q, arr_data_q;
  logic [1:0]  acc_q, pv_q;
  logic        divld_q, bank_q, cbe_q, done_q, word_q, cmdv_q, sup_q, pend_q;
  int          act_q, n_launch;
  wire  [8:0]  ra    = addr_i[8:0];
  wire         w_st  = reg_wr_i && ra == FPS_DEV_STATUS;
  wire         legal = wdata_i[7:0] inside {FPS_CMD_ERASE_VERIFY, FPS_CMD_WORD_PROGRAM,
                                            FPS_CMD_SECTOR_ERASE, FPS_CMD_MASS_ERASE};
  assign rd_d = (ra == FPS_DEV_STATUS) ? {cbe_q, done_q, pv_q[bank_q], acc_q[bank_q], 4'h0} :
                (ra == FPS_DEV_CONFIG) ? {7'h00, bank_q} : {divld_q, div_q[6:0]};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {div_q, cmd_q, arr_addr_q, arr_data_q, acc_q, pv_q} <= '0;
      {divld_q, bank_q, word_q, cmdv_q, sup_q, pend_q} <= '0;
      {cbe_q, done_q} <= 2'b11;
      act_q <= 0;
      n_launch <= 0;
      rdata_o <= 8'h00;
    end else begin
      // a released read bus shows the inverse of its last value
      rdata_o <= reg_rd_i ? rd_d : ~rdata_o;
      if (err_set_i)
        acc_q[1] <= 1'b1;
      if (reg_wr_i && ra == FPS_DEV_CLKDIV) begin
        div_q <= wdata_i[7:0];
        divld_q <= 1'b1;
      end
      if (reg_wr_i && ra == FPS_DEV_CONFIG)
        bank_q <= wdata_i[0];
      // word write needs a loaded divider and an empty buffer
      if (arr_wr_i) begin
        if (!divld_q || !cbe_q || word_q)
          acc_q[bank_q] <= 1'b1;
        word_q <= 1'b1;
        arr_addr_q <= addr_i;
        arr_data_q <= wdata_i;
      end
      // data register must come straight after address register
      if (reg_wr_i)
        sup_q <= ra == FPS_DEV_ADDR;
      if (reg_wr_i && ra == FPS_DEV_ADDR)
        arr_addr_q <= wdata_i;
      if (reg_wr_i && ra == FPS_DEV_DATA) begin
        if (!sup_q)
          acc_q[bank_q] <= 1'b1;
        word_q <= sup_q;
        arr_data_q <= wdata_i;
      end
      if (reg_wr_i && ra == FPS_DEV_CMD) begin
        if (!word_q || !legal)
          acc_q[bank_q] <= 1'b1;
        cmdv_q <= word_q && legal;
        cmd_q <= wdata_i[7:0];
      end
      // error flags clear only on a written one
      if (w_st) begin
        pv_q[bank_q] <= pv_q[bank_q] & ~wdata_i[5];
        acc_q[bank_q] <= acc_q[bank_q] & ~wdata_i[4];
      end
      // pending command moves up after one idle cycle, freeing the buffer
      if (pend_q && act_q == 0) begin
        act_q <= RUN_CYC;
        pend_q <= 1'b0;
        cbe_q <= 1'b1;
      end else if (act_q != 0)
        act_q <= act_q - 1;
      // completion only when nothing is active or pending
      if (act_q == 1 && !pend_q)
        done_q <= 1'b1;
      // launch needs a full buffer and no error in any bank
      if (w_st && wdata_i[7] && cmdv_q && !(|acc_q) && !(|pv_q) && divld_q) begin
        {cbe_q, done_q, word_q, cmdv_q} <= 4'b0000;
        pend_q <= 1'b1;
        n_launch <= n_launch + 1;
      end
      // a zero written to buffer-empty aborts the sequence
      if (w_st && !wdata_i[7] && (word_q || cmdv_q)) begin
        acc_q[bank_q] <= 1'b1;
        {word_q, cmdv_q} <= 2'b00;
      end
    end
  end
endmodule

// file: verification/testbench.sv
/* Self-checking bench for the flash host controller with a device model.
   Assumes the register map and command codes of the package. */
`timescale 1ns/1ps
module testbench
  import fps_pkg::*;
;
  logic        clk_sys_i, rst_n_i, sw_wr_i, sw_rd_i, err_set;
  logic [3:0]  sw_addr_i;
  logic [15:0] sw_wdata_i, v;
  logic [15:0] sw_rdata_o, dev_addr_o, dev_wdata_o;
  logic        dev_reg_wr_o, dev_reg_rd_o, dev_arr_wr_o;
  logic [7:0]  dev_rdata_i;
  logic [7:0]  ec [3] = '{FPS_CMD_ERASE_VERIFY, FPS_CMD_SECTOR_ERASE, FPS_CMD_MASS_ERASE};
  int          n_mismatch = 0, check_count = 0, nl;

  fps_host dut (.*);
  fps_dev_model dev (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(dev_reg_wr_o),
    .reg_rd_i(dev_reg_rd_o), .arr_wr_i(dev_arr_wr_o), .addr_i(dev_addr_o),
    .wdata_i(dev_wdata_o), .err_set_i(err_set), .rdata_o(dev_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask

  // loads the operands, starts the controller and polls until it is idle
  task automatic op(input logic [15:0] a, d, input logic [7:0] c, input logic [15:0] ctl,
                    output logic [15:0] st);
    int i;
    wr(FPS_REG_ADDR, a);
    wr(FPS_REG_DATA, d);
    wr(FPS_REG_CMD, {8'h00, c});
    wr(FPS_REG_CTRL, ctl);
    for (i = 0; i < 300; i++) begin
      rd(FPS_REG_STATUS, st);
      if (st[FPS_STS_BUSY] === 1'b0)
        break;
    end
    if (i == 300) begin
      n_mismatch++;
      $display("[FAIL] busy expected 0 got 1");
      stop_test();
    end
  endtask

  initial begin
    {rst_n_i, sw_wr_i, sw_rd_i, err_set, sw_addr_i, sw_wdata_i} <= '0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(FPS_REG_STATUS, v);
    chk("reset status", 16'h0008, v);
    wr(FPS_REG_DIV, 16'h0000);
    op(16'h4122, 16'habcd, FPS_CMD_WORD_PROGRAM, 16'h0021, v);
    chk("bad divider status", 16'h000a, v & 16'h000a);
    chk("divider untouched", 16'h0000, {15'h0000, dev.divld_q});
    wr(FPS_REG_STATUS, 16'h0002);
    wr(FPS_REG_DIV, 16'h0014);
    wr(4'hf, 16'hffff);
    rd(FPS_REG_DIV, v);
    chk("divider after stray write", 16'h0014, v);
    $display("test divider done");
    op(16'h4122, 16'habcd, FPS_CMD_WORD_PROGRAM, 16'h0021, v);
    chk("program status", 16'h0010, v & 16'h0013);
    chk("program addr", 16'h4122, dev.arr_addr_q);
    chk("program data", 16'habcd, dev.arr_data_q);
    chk("device divider", 16'h0014, {8'h00, dev.div_q});
    $display("test program done");
    foreach (ec[k]) begin
      op(16'h41ff, 16'h5a5a, ec[k], 16'h0021, v);
      chk("erase status", 16'h0010, v & 16'h0013);
      chk("erase cmd", {8'h00, ec[k]}, {8'h00, dev.cmd_q});
      chk("erase addr", (ec[k] == FPS_CMD_SECTOR_ERASE) ? 16'h4000 : 16'h41fe,
          dev.arr_addr_q);
      if (ec[k] != FPS_CMD_ERASE_VERIFY)
        chk("erase data", 16'h0000, dev.arr_data_q);
    end
    $display("test erase done");
    nl = dev.n_launch;
    op(16'h4122, 16'h1111, 8'h33, 16'h0021, v);
    chk("illegal cmd error", 16'h0002, v & 16'h0003);
    chk("illegal cmd launches", nl[15:0], dev.n_launch[15:0]);
    wr(FPS_REG_STATUS, 16'h0002);
    rd(FPS_REG_STATUS, v);
    chk("error cleared", 16'h0000, v & 16'h0002);
    $display("test illegal done");
    @(posedge clk_sys_i);
    err_set <= 1'b1;
    @(posedge clk_sys_i);
    err_set <= 1'b0;
    op(16'h4200, 16'h1234, FPS_CMD_WORD_PROGRAM, 16'h0023, v);
    chk("bank error status", 16'h0010, v & 16'h0013);
    chk("bank error cleared", 16'h0000, {14'h0000, dev.acc_q});
    $display("test bank error done");
    op(16'h4300, 16'h0f0f, FPS_CMD_WORD_PROGRAM, 16'h0025, v);
    chk("super status", 16'h0010, v & 16'h0013);
    chk("super addr", 16'h4300, dev.arr_addr_q);
    chk("super data", 16'h0f0f, dev.arr_data_q);
    $display("test super done");
    nl = dev.n_launch + 2;
    op(16'h4400, 16'h2222, FPS_CMD_WORD_PROGRAM, 16'h0001, v);
    op(16'h4402, 16'h3333, FPS_CMD_WORD_PROGRAM, 16'h0021, v);
    chk("queued status", 16'h0010, v & 16'h0013);
    chk("queued launches", nl[15:0], dev.n_launch[15:0]);
    $display("test queue done");
    stop_test();
  end
endmodule

bind fps_host fps_host_properties #(.OSC_HZ(OSC_HZ)) u_props (.*);
